// ==== spi_buffer_baud_event_regs.sv ====
`timescale 1ns/1ps
module spi_buffer_baud_event_regs #(
	parameter int QUEUE_DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire spi_regs_pkg::apb_req_t apb_req,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// Configuration from the control registers
	input wire logic module_on,
	input wire logic [4:0] variable_word_length,
	input wire logic [1:0] wide_mode,
	input wire logic underrun_fill_en,
	// Status from the shifter and queues
	input wire spi_regs_pkg::status_t status,
	input wire logic [5:0] rx_element_count,
	input wire logic [5:0] tx_element_count,
	// Receive queue head
	input wire logic [31:0] rx_word,
	output logic rx_pop,
	// Transmit queue entry
	input wire logic tx_ready,
	output logic tx_push,
	output logic [31:0] tx_word,
	// Word handed to the shifter
	output logic [31:0] shift_word,
	// Bit clock and interrupt
	output logic baud_clk,
	output logic irq
);
	import spi_regs_pkg::*;

	if (QUEUE_DEPTH != 4 && QUEUE_DEPTH != 8 &&
		QUEUE_DEPTH != 16 && QUEUE_DEPTH != 32) begin : g_bad_depth
		$error("queue depth must be 4, 8, 16 or 32");
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [5:0] eff_len(input logic [4:0] wl,
		input logic [1:0] md);
		if (wl != 5'h00) begin
			eff_len = {1'b0, wl} + 6'h01;
		end else if (md == MODE_8) begin
			eff_len = LEN_8;
		end else if (md == MODE_16) begin
			eff_len = LEN_16;
		end else begin
			eff_len = LEN_32;
		end
	endfunction : eff_len

	function automatic logic [31:0] lane_mask(input logic [5:0] len);
		if (len <= LEN_8) begin
			lane_mask = LANE_8;
		end else if (len <= LEN_16) begin
			lane_mask = LANE_16;
		end else if (len <= LEN_24) begin
			lane_mask = LANE_24;
		end else begin
			lane_mask = LANE_32;
		end
	endfunction : lane_mask

	function automatic logic [5:0] level_impl(input int depth);
		level_impl = 6'h23;
		if (depth >= 8) begin
			level_impl[2] = 1'b1;
		end
		if (depth >= 16) begin
			level_impl[3] = 1'b1;
		end
		if (depth >= 32) begin
			level_impl[4] = 1'b1;
		end
	endfunction : level_impl

	localparam logic [5:0] LVL_IMPL = level_impl(QUEUE_DEPTH);
	localparam logic [5:0] DEPTH_LVL = 6'(QUEUE_DEPTH);

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	logic [5:0] cur_len;
	logic [31:0] cur_mask;
	logic setup;
	logic access;
	logic mapped;
	logic done;
	logic wr;
	logic low_stall;

	assign cur_len = eff_len(variable_word_length, wide_mode);
	assign cur_mask = lane_mask(cur_len);
	assign setup = apb_req.psel && !apb_req.penable;
	assign access = apb_req.psel && apb_req.penable;
	assign mapped = apb_req.paddr == OFS_DATA_LOW ||
		apb_req.paddr == OFS_DATA_HIGH || apb_req.paddr == OFS_BAUD ||
		apb_req.paddr == OFS_EVT_EN || apb_req.paddr == OFS_WM_EN ||
		apb_req.paddr == OFS_FILL_LOW;
	// A push into a full transmit queue waits here rather than drop data.
	assign low_stall = access && apb_req.pwrite &&
		apb_req.paddr == OFS_DATA_LOW && !tx_ready;
	assign pready = !low_stall;
	assign pslverr = access && !mapped;
	assign done = access && pready;
	assign wr = done && apb_req.pwrite && mapped;

	// ---------------------------------------------------------------
	// Software registers
	// ---------------------------------------------------------------
	logic [15:0] hi_hold_q;
	logic [BAUD_W-1:0] baud_div_q;
	logic [15:0] evt_en_q;
	logic [15:0] wm_en_q;
	logic [15:0] fill_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hi_hold_q <= REG_RST;
			baud_div_q <= BAUD_RST;
			evt_en_q <= REG_RST;
			wm_en_q <= REG_RST;
			fill_q <= REG_RST;
		end else if (wr) begin
			case (apb_req.paddr)
				OFS_DATA_HIGH: hi_hold_q <= apb_req.pwdata[15:0];
				OFS_BAUD: baud_div_q <= apb_req.pwdata[BAUD_W-1:0];
				OFS_EVT_EN: evt_en_q <= apb_req.pwdata[15:0] & EVT_IMPL;
				OFS_WM_EN: begin
					wm_en_q <= {apb_req.pwdata[WM_RX_EN], 1'b0,
						apb_req.pwdata[WM_RX_LSB +: LVL_W] & LVL_IMPL,
						apb_req.pwdata[WM_TX_EN], 1'b0,
						apb_req.pwdata[WM_TX_LSB +: LVL_W] & LVL_IMPL};
				end
				OFS_FILL_LOW: fill_q <= apb_req.pwdata[15:0];
				default: fill_q <= fill_q;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Data window
	// ---------------------------------------------------------------
	// The high half is staged and the word is pushed on the low write,
	// so software writes high first for words longer than 16 bits.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_word <= '0;
			tx_push <= 1'b0;
		end else begin
			tx_push <= wr && apb_req.paddr == OFS_DATA_LOW;
			if (wr && apb_req.paddr == OFS_DATA_LOW) begin
				tx_word <= {hi_hold_q, apb_req.pwdata[15:0]} & cur_mask;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_pop <= 1'b0;
		end else begin
			rx_pop <= done && !apb_req.pwrite &&
				apb_req.paddr == OFS_DATA_LOW;
		end
	end

	// ---------------------------------------------------------------
	// Read data, captured in the setup cycle
	// ---------------------------------------------------------------
	logic [31:0] rx_masked;
	assign rx_masked = rx_word & cur_mask;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= '0;
		end else if (setup) begin
			case (apb_req.paddr)
				OFS_DATA_LOW: prdata <= {16'h0000, rx_masked[15:0]};
				OFS_DATA_HIGH: prdata <= {16'h0000, rx_masked[31:16]};
				OFS_BAUD: prdata <= {19'h00000, baud_div_q};
				OFS_EVT_EN: prdata <= {16'h0000, evt_en_q};
				OFS_WM_EN: prdata <= {16'h0000, wm_en_q};
				OFS_FILL_LOW: prdata <= {16'h0000, fill_q};
				default: prdata <= '0;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Underrun fill
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_word <= '0;
		end else if (underrun_fill_en && status.underrun_flag) begin
			shift_word <= {16'h0000, fill_q} & cur_mask;
		end else begin
			shift_word <= tx_word;
		end
	end

	// ---------------------------------------------------------------
	// Baud generator
	// ---------------------------------------------------------------
	logic [BAUD_W-1:0] baud_cnt_q;

	// half period of divisor plus one
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			baud_cnt_q <= '0;
			baud_clk <= 1'b0;
		end else if (!module_on) begin
			baud_cnt_q <= '0;
			baud_clk <= 1'b0;
		end else if (baud_cnt_q >= baud_div_q) begin
			baud_cnt_q <= '0;
			baud_clk <= !baud_clk;
		end else begin
			baud_cnt_q <= baud_cnt_q + 13'h0001;
		end
	end

	// ---------------------------------------------------------------
	// Events and watermarks
	// ---------------------------------------------------------------
	logic [15:0] evt_src;
	logic [5:0] rx_lvl;
	logic [5:0] tx_lvl;
	logic rx_wm;
	logic tx_wm;

	always_comb begin
		evt_src = '0;
		evt_src[EVT_FRAME] = status.frame_error_flag;
		evt_src[EVT_ACTIVITY] = status.activity_flag;
		evt_src[EVT_UNDERRUN] = status.underrun_flag;
		evt_src[EVT_SHIFT_EMPTY] = status.shifter_empty_flag;
		evt_src[EVT_OVERFLOW] = status.overflow_flag;
		evt_src[EVT_RX_EMPTY] = status.rx_empty_flag;
		evt_src[EVT_TX_EMPTY] = status.tx_empty_flag;
		evt_src[EVT_TX_FULL] = status.tx_full_flag;
		evt_src[EVT_RX_FULL] = status.rx_full_flag;
	end

	assign rx_lvl = wm_en_q[WM_RX_LSB +: LVL_W];
	assign tx_lvl = wm_en_q[WM_TX_LSB +: LVL_W];
	assign rx_wm = wm_en_q[WM_RX_EN] && rx_lvl <= DEPTH_LVL &&
		rx_lvl <= rx_element_count;
	assign tx_wm = wm_en_q[WM_TX_EN] && tx_lvl <= DEPTH_LVL &&
		tx_lvl == tx_element_count;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= (|(evt_src & evt_en_q)) || rx_wm || tx_wm;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_baud_read;
		setup && !apb_req.pwrite && apb_req.paddr == OFS_BAUD;
	endsequence

	property p_baud_top;
		s_baud_read |=> prdata[31:BAUD_W] == '0 && prdata[BAUD_W-1:0] ==
			$past(baud_div_q);
	endproperty
	a_baud_top: assert property (p_baud_top)
		else $error("baud read shows bad upper bits or value");

	property p_short_push;
		tx_push && cur_len <= LEN_8 && $stable(cur_len) |->
			tx_word[31:8] == '0;
	endproperty
	a_short_push: assert property (p_short_push)
		else $error("short word uses lanes above eight bits");

	property p_mid_push;
		tx_push && cur_len > LEN_16 && cur_len <= LEN_24 &&
			$stable(cur_len) |-> tx_word[31:24] == '0 &&
			tx_word[23:16] == $past(hi_hold_q[7:0]);
	endproperty
	a_mid_push: assert property (p_mid_push)
		else $error("upper half lane use wrong for 17 to 24 bits");

	property p_frame_evt;
		status.frame_error_flag && evt_en_q[EVT_FRAME] |=> irq;
	endproperty
	a_frame_evt: assert property (p_frame_evt)
		else $error("enabled frame error gave no interrupt");

	property p_underrun_evt;
		status.underrun_flag && evt_en_q[EVT_UNDERRUN] |=> irq;
	endproperty
	a_underrun_evt: assert property (p_underrun_evt)
		else $error("enabled underrun gave no interrupt");

	property p_rx_wm;
		wm_en_q[WM_RX_EN] && rx_lvl <= DEPTH_LVL &&
			rx_lvl <= rx_element_count |=> irq;
	endproperty
	a_rx_wm: assert property (p_rx_wm)
		else $error("receive watermark reached but no interrupt");

	property p_tx_wm_bad;
		(evt_src & evt_en_q) == '0 && !wm_en_q[WM_RX_EN] &&
			(tx_lvl > DEPTH_LVL || tx_lvl != tx_element_count) |=> !irq;
	endproperty
	a_tx_wm_bad: assert property (p_tx_wm_bad)
		else $error("transmit watermark matched without equality");

	property p_quiet;
		(evt_src & evt_en_q) == '0 && !rx_wm && !tx_wm |=> !irq;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("interrupt raised with no enabled cause");

	sequence s_fill_cause;
		underrun_fill_en && status.underrun_flag;
	endsequence

	property p_fill;
		s_fill_cause |=> shift_word == ({16'h0000, $past(fill_q)} &
			$past(cur_mask));
	endproperty
	a_fill: assert property (p_fill)
		else $error("underrun did not send the fill word");

	property p_baud_toggle;
		module_on && baud_cnt_q >= baud_div_q |=> $changed(baud_clk) ||
			!module_on;
	endproperty
	a_baud_toggle: assert property (p_baud_toggle)
		else $error("bit clock missed its half-period toggle");

	property p_baud_hold;
		module_on && baud_cnt_q < baud_div_q ##1 module_on |->
			$stable(baud_clk);
	endproperty
	a_baud_hold: assert property (p_baud_hold)
		else $error("bit clock toggled early");

endmodule : spi_buffer_baud_event_regs

// ==== spi_regs_pkg.sv ====
package spi_regs_pkg;

	// ---------------------------------------------------------------
	// Register map, byte addresses on the APB word grid
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_DATA_LOW = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_DATA_HIGH = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_BAUD = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_EVT_EN = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_WM_EN = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_FILL_LOW = 8'h14;

	// ---------------------------------------------------------------
	// Field layouts and reset values
	// ---------------------------------------------------------------
	localparam int BAUD_W = 13;
	localparam logic [BAUD_W-1:0] BAUD_RST = 13'h0000;
	localparam logic [15:0] EVT_IMPL = 16'h19eb;
	localparam int EVT_FRAME = 12;
	localparam int EVT_ACTIVITY = 11;
	localparam int EVT_UNDERRUN = 8;
	localparam int EVT_SHIFT_EMPTY = 7;
	localparam int EVT_OVERFLOW = 6;
	localparam int EVT_RX_EMPTY = 5;
	localparam int EVT_TX_EMPTY = 3;
	localparam int EVT_TX_FULL = 1;
	localparam int EVT_RX_FULL = 0;
	localparam int WM_RX_EN = 15;
	localparam int WM_RX_LSB = 8;
	localparam int WM_TX_EN = 7;
	localparam int WM_TX_LSB = 0;
	localparam int LVL_W = 6;
	localparam logic [15:0] REG_RST = 16'h0000;

	// ---------------------------------------------------------------
	// Word lengths and lane masks
	// ---------------------------------------------------------------
	localparam logic [5:0] LEN_8 = 6'h08;
	localparam logic [5:0] LEN_16 = 6'h10;
	localparam logic [5:0] LEN_24 = 6'h18;
	localparam logic [5:0] LEN_32 = 6'h20;
	localparam logic [1:0] MODE_8 = 2'h0;
	localparam logic [1:0] MODE_16 = 2'h1;
	localparam logic [31:0] LANE_8 = 32'h0000_00ff;
	localparam logic [31:0] LANE_16 = 32'h0000_ffff;
	localparam logic [31:0] LANE_24 = 32'h00ff_ffff;
	localparam logic [31:0] LANE_32 = 32'hffff_ffff;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic frame_error_flag;
		logic activity_flag;
		logic underrun_flag;
		logic shifter_empty_flag;
		logic overflow_flag;
		logic rx_empty_flag;
		logic tx_empty_flag;
		logic tx_full_flag;
		logic rx_full_flag;
	} status_t;

endpackage : spi_regs_pkg

// ==== spi_queue_model.sv ====
`timescale 1ns/1ps
// ----
// Queue stand-in
// ----
module spi_queue_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Design side
	input wire logic tx_push,
	input wire logic [31:0] tx_word,
	input wire logic rx_pop,
	input wire logic stall,
	output logic tx_ready,
	output logic [31:0] rx_word,
	output logic [31:0] got_word
);
	// The head word changes on every pop, so a read that misses the pop
	// or repeats a stale value shows up as a wrong half.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_word <= 32'ha5a5_5a5a;
			got_word <= 32'h0;
		end else begin
			if (rx_pop)
				rx_word <= ~rx_word;
			if (tx_push)
				got_word <= tx_word;
		end
	end
	assign tx_ready = !stall;
endmodule : spi_queue_model

// ==== tb.sv ====
`timescale 1ns/1ps
// ----
// Bench top
// ----
module tb;
	import spi_regs_pkg::*;
	logic clk = 0;
	logic rst = 1;
	apb_req_t req = '0;
	status_t status = '0;
	logic module_on = 0;
	logic fill_en = 0;
	logic stall = 0;
	logic [4:0] wlen = 0;
	logic [1:0] wmode = 0;
	logic [5:0] rx_cnt = 0;
	logic [5:0] tx_cnt = 0;
	logic pready, pslverr, rx_pop, tx_push, tx_ready, baud_clk, irq, err;
	logic [31:0] prdata, tx_word, shift_word, rx_word, got_word, rd;
	int fail_count = 0;
	int checks_done = 0;
	int waits;
	int n;
	int ebit[9] = '{12, 11, 8, 7, 6, 5, 3, 1, 0};
	always #4 clk = ~clk;

	spi_buffer_baud_event_regs #(.QUEUE_DEPTH(8)) dut_u (
		.clk(clk), .rst(rst), .apb_req(req), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .module_on(module_on),
		.variable_word_length(wlen), .wide_mode(wmode),
		.underrun_fill_en(fill_en), .status(status),
		.rx_element_count(rx_cnt), .tx_element_count(tx_cnt),
		.rx_word(rx_word), .rx_pop(rx_pop), .tx_ready(tx_ready),
		.tx_push(tx_push), .tx_word(tx_word), .shift_word(shift_word),
		.baud_clk(baud_clk), .irq(irq)
	);
	spi_queue_model far_u (
		.clk(clk), .rst(rst), .tx_push(tx_push), .tx_word(tx_word),
		.rx_pop(rx_pop), .stall(stall), .tx_ready(tx_ready),
		.rx_word(rx_word), .got_word(got_word)
	);

	// ----
	// Tasks
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : cyc

	// The request stands until pready is seen at an edge; one idle
	// cycle follows so the strobe is never set twice in a time step.
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		waits = 0;
		do begin
			@(posedge clk);
			waits++;
		end while (pready !== 1'b1 && waits < 60);
		if (pready !== 1'b1) begin
			fail_count++;
			$display("[ERR] %0t no bus answer", $time);
		end
		rd = prdata;
		err = pslverr;
		req <= '0;
		@(posedge clk);
	endtask : xfer

	task automatic half();
		logic b;
		b = baud_clk;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (baud_clk === b && n < 100);
	endtask : half

	task automatic wm(input logic [15:0] v, input logic [5:0] r,
		input logic [5:0] t, input logic e);
		xfer(1'b1, OFS_WM_EN, {16'h0, v});
		rx_cnt <= r;
		tx_cnt <= t;
		cyc(3);
		check(irq, e);
	endtask : wm

	task automatic lane(input logic [4:0] l, input logic [1:0] m,
		input logic [31:0] e);
		wlen <= l;
		wmode <= m;
		xfer(1'b1, OFS_DATA_HIGH, 32'habcd);
		xfer(1'b1, OFS_DATA_LOW, 32'h1234);
		cyc(1);
		check(got_word, e);
	endtask : lane

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	initial begin
		#20000;
		$display("[ERR] %0t watchdog expired", $time);
		fail_count++;
		print_verdict();
	end

	// ----
	// Tests
	// ----
	initial begin
		cyc(6);
		rst <= 1'b0;
		for (int i = 2; i < 6; i++) begin
			xfer(1'b0, 8'(i * 4), 32'h0);
			check(rd, 32'h0);
		end
		xfer(1'b1, 8'h18, 32'hffff);
		xfer(1'b0, 8'h18, 32'h0);
		check(rd, 32'h0);
		check(err, 1'b1);
		$display("test reset done");
		xfer(1'b1, OFS_BAUD, 32'hffff);
		xfer(1'b0, OFS_BAUD, 32'h0);
		check(rd, 32'h1fff);
		xfer(1'b1, OFS_BAUD, 32'h3);
		check(baud_clk, 1'b0);
		module_on <= 1'b1;
		half();
		half();
		check(32'(n), 32'd4);
		module_on <= 1'b0;
		$display("test baud done");
		xfer(1'b1, OFS_EVT_EN, 32'hffff);
		xfer(1'b0, OFS_EVT_EN, 32'h0);
		check(rd, 32'h19eb);
		for (int i = 0; i < 9; i++) begin
			status <= status_t'(9'h100 >> i);
			xfer(1'b1, OFS_EVT_EN, 32'h1 << ebit[i]);
			cyc(2);
			check(irq, 1'b1);
			xfer(1'b1, OFS_EVT_EN, 32'h19eb ^ (32'h1 << ebit[i]));
			cyc(2);
			check(irq, 1'b0);
		end
		status <= '0;
		xfer(1'b1, OFS_EVT_EN, 32'h0);
		$display("test events done");
		xfer(1'b1, OFS_WM_EN, 32'hffff);
		xfer(1'b0, OFS_WM_EN, 32'h0);
		check(rd, 32'ha7a7);
		wm(16'h8300, 6'd2, 6'd0, 1'b0);
		wm(16'h8300, 6'd3, 6'd0, 1'b1);
		wm(16'h8300, 6'd5, 6'd0, 1'b1);
		wm(16'h0083, 6'd5, 6'd3, 1'b1);
		wm(16'h0083, 6'd0, 6'd4, 1'b0);
		wm(16'h0083, 6'd0, 6'd2, 1'b0);
		wm(16'ha000, 6'd63, 6'd0, 1'b0);
		wm(16'h00a0, 6'd0, 6'd32, 1'b0);
		wm(16'h0000, 6'd0, 6'd0, 1'b0);
		$display("test watermark done");
		lane(5'd7, 2'h0, 32'h34);
		lane(5'd15, 2'h0, 32'h1234);
		lane(5'd23, 2'h0, 32'hcd1234);
		lane(5'd31, 2'h0, 32'habcd1234);
		lane(5'd0, MODE_8, 32'h34);
		lane(5'd0, MODE_16, 32'h1234);
		lane(5'd0, 2'h2, 32'habcd1234);
		lane(5'd0, 2'h3, 32'habcd1234);
		stall <= 1'b1;
		fork
			lane(5'd15, 2'h0, 32'h1234);
			begin
				cyc(8);
				stall <= 1'b0;
			end
		join
		check(waits > 2, 1'b1);
		wlen <= 5'd31;
		xfer(1'b0, OFS_DATA_HIGH, 32'h0);
		check(rd, 32'ha5a5);
		xfer(1'b0, OFS_DATA_LOW, 32'h0);
		check(rd, 32'h5a5a);
		wlen <= 5'd7;
		xfer(1'b0, OFS_DATA_LOW, 32'h0);
		check(rd, 32'ha5);
		$display("test lanes done");
		xfer(1'b1, OFS_FILL_LOW, 32'hbeef);
		xfer(1'b0, OFS_FILL_LOW, 32'h0);
		check(rd, 32'hbeef);
		fill_en <= 1'b1;
		status <= status_t'(9'h040);
		cyc(2);
		check(shift_word, 32'hef);
		fill_en <= 1'b0;
		cyc(2);
		check(shift_word, 32'h1234);
		$display("test underrun done");
		rst <= 1'b1;
		status <= '0;
		cyc(2);
		rst <= 1'b0;
		xfer(1'b0, OFS_FILL_LOW, 32'h0);
		check(rd, 32'h0);
		xfer(1'b0, OFS_BAUD, 32'h0);
		check(rd, 32'h0);
		$display("test second reset done");
		print_verdict();
	end
endmodule : tb
